// file: design/torque_limit_pkg.sv
// shared constants and carrier types for the torque limit selector
// assumes a single controller clock domain
`default_nettype none
package torque_limit_pkg;
  // ------------------------------------------------------------
  // table geometry and value encoding (hundredths of rated torque)
  // ------------------------------------------------------------
  localparam int unsigned ENTRIES = 8;
  localparam int unsigned IDX_W = 3;
  localparam int unsigned VAL_W = 10;
  localparam logic [9:0] LIMIT_MIN = 10'h001;
  localparam logic [9:0] LIMIT_MAX = 10'h3E7;
  localparam logic [9:0] LIMIT_RATED = 10'h064;
  localparam logic [9:0] LIMIT_RESET = 10'h12C;
  localparam logic [9:0] LIMIT_NONE = 10'h3FF;
  // ------------------------------------------------------------
  // register map of the plain port
  // ------------------------------------------------------------
  localparam logic [7:0] ADDR_TABLE0 = 8'h00;
  localparam logic [7:0] ADDR_INST_MAX = 8'h08;
  localparam logic [7:0] ADDR_SEL_BIT = 8'h09;
  localparam logic [7:0] ADDR_STATUS = 8'h0A;
  localparam logic [9:0] INST_MAX_RESET = 10'h12C;
  localparam logic [3:0] SEL_BIT_RESET = 4'h0;
  localparam int unsigned SYNC_STAGES = 2;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [15:0] wdata;
  } reg_req_t;
endpackage
`default_nettype wire

// file: design/torque_limit_table.sv
// eight-entry limit table with registered read port
// assumes writes already range checked by the parent
`timescale 1ns/1ps
`default_nettype none
module torque_limit_table #(
  parameter int unsigned DEPTH = 8,
  parameter int unsigned WIDTH = 10
) (
  input wire logic i_mclk,
  input wire logic i_rst,
  input wire logic i_we,
  input wire logic [$clog2(DEPTH)-1:0] i_waddr,
  input wire logic [WIDTH-1:0] i_wdata,
  input wire logic [$clog2(DEPTH)-1:0] i_raddr,
  output logic [WIDTH-1:0] o_rdata
);
  logic [WIDTH-1:0] mem_q [DEPTH];

  // ------------------------------------------------------------
  // storage, reset to three times rated
  // ------------------------------------------------------------
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem_q[i] <= WIDTH'(torque_limit_pkg::LIMIT_RESET);
      end
    end else if (i_we) begin
      mem_q[i_waddr] <= i_wdata;
    end
  end

  // write-through so a new value is seen with no extra wait
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      o_rdata <= WIDTH'(torque_limit_pkg::LIMIT_RESET);
    end else if (i_we && i_waddr == i_raddr) begin
      o_rdata <= i_wdata;
    end else begin
      o_rdata <= mem_q[i_raddr];
    end
  end
endmodule // torque_limit_table
`default_nettype wire

// file: design/bit_sync.sv
// two-flop synchroniser for a group of level inputs
// assumes inputs are plain levels from outside
`timescale 1ns/1ps
`default_nettype none
module bit_sync #(
  parameter int unsigned WIDTH = 3
) (
  input wire logic i_mclk,
  input wire logic i_rst,
  input wire logic [WIDTH-1:0] i_d,
  output logic [WIDTH-1:0] o_q
);
  logic [WIDTH-1:0] meta_q;

  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      meta_q <= '0;
      o_q <= '0;
    end else begin
      meta_q <= i_d;
      o_q <= meta_q;
    end
  end
endmodule // bit_sync
`default_nettype wire

// file: design/max_torque_limit_select.sv
// maximum torque limit selector: table, index decode, clamp chain
// assumes one controller clock, synchronous register port
//
// Function
// - eight limit entries are held and one is chosen by three adjacent input port bits
// - the three bits form a binary value, lowest bit weight one, entry number is value plus one
// - each entry is a multiple of rated torque in hundredths, 100 meaning rated
// - entries accept 1 to 999 hundredths, other writes are refused
// - the output limit never exceeds the motor instantaneous maximum
// - after reset all entries hold 300 hundredths
// - a rewritten entry takes effect at once, without waiting for motion
// - a change of selection bits during motion switches to the new entry
// - during return to origin the selected limit is ignored
// - with another limit source active the lower of the two applies
//
// The placing of the registers and the address-and-strobe port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module max_torque_limit_select #(
  parameter int unsigned ENTRIES = 8,
  parameter int unsigned VAL_W = 10,
  parameter int unsigned PORT_W = 16
) (
  input wire logic i_mclk,
  input wire logic i_rst,
  input wire logic [PORT_W-1:0] i_gp_in,
  input wire logic i_homing,
  input wire logic i_moving,
  input wire logic i_ext_limit_valid,
  input wire logic [VAL_W-1:0] i_ext_limit,
  input wire logic [7:0] i_addr,
  input wire logic [15:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [15:0] o_rdata,
  output logic [VAL_W-1:0] o_torque_limit_value,
  output logic o_limit_active,
  output logic [2:0] o_entry_index
);
  localparam int unsigned IDX_W = $clog2(ENTRIES);

  // ------------------------------------------------------------
  // elaboration checks
  // ------------------------------------------------------------
  // index output and table decode are built for exactly eight entries
  if (ENTRIES != torque_limit_pkg::ENTRIES) begin : g_bad_entries
    $error("ENTRIES must equal the table size");
  end
  // value must fit the low part of the 16-bit write word
  if (VAL_W < torque_limit_pkg::VAL_W || VAL_W > 15) begin : g_bad_width
    $error("VAL_W out of range");
  end
  // three adjacent bits must fit inside the port
  if (PORT_W < 3 || PORT_W > 16) begin : g_bad_port
    $error("PORT_W out of range");
  end

  // ------------------------------------------------------------
  // request bundle
  // ------------------------------------------------------------
  torque_limit_pkg::reg_req_t req;
  assign req = '{wr: i_wr, rd: i_rd, addr: i_addr, wdata: i_wdata};

  // ------------------------------------------------------------
  // configuration registers
  // ------------------------------------------------------------
  logic [VAL_W-1:0] inst_max_q;
  logic [3:0] sel_bit_q;
  logic wr_table;
  logic wr_ok;

  assign wr_table = req.wr && req.addr < 8'(ENTRIES);
  // refuse out of range values, keep the old entry
  assign wr_ok = wr_table && req.wdata[VAL_W-1:0] >= VAL_W'(torque_limit_pkg::LIMIT_MIN)
    && req.wdata[VAL_W-1:0] <= VAL_W'(torque_limit_pkg::LIMIT_MAX)
    && req.wdata[15:VAL_W] == '0;

  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      inst_max_q <= VAL_W'(torque_limit_pkg::INST_MAX_RESET);
    end else if (req.wr && req.addr == torque_limit_pkg::ADDR_INST_MAX) begin
      inst_max_q <= req.wdata[VAL_W-1:0];
    end
  end

  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      sel_bit_q <= torque_limit_pkg::SEL_BIT_RESET;
    end else if (req.wr && req.addr == torque_limit_pkg::ADDR_SEL_BIT
                 && req.wdata <= 16'(PORT_W - 3)) begin
      sel_bit_q <= req.wdata[3:0];
    end
  end

  // ------------------------------------------------------------
  // selection bits: synchronise, pick field, accept when stable
  // ------------------------------------------------------------
  logic [PORT_W-1:0] gp_sync;
  logic [IDX_W-1:0] sel_raw;
  logic [IDX_W-1:0] sel_prev_q;
  logic [IDX_W-1:0] idx_q;

  bit_sync #(
    .WIDTH(PORT_W)
  ) u_sync (
    .i_mclk(i_mclk),
    .i_rst(i_rst),
    .i_d(i_gp_in),
    .o_q(gp_sync)
  );

  assign sel_raw = gp_sync[sel_bit_q +: IDX_W];

  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      sel_prev_q <= '0;
    end else begin
      sel_prev_q <= sel_raw;
    end
  end

  // index follows two equal samples, moving or not
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      idx_q <= '0;
    end else if (sel_raw == sel_prev_q) begin
      idx_q <= sel_raw;
    end
  end

  // ------------------------------------------------------------
  // table
  // ------------------------------------------------------------
  logic [VAL_W-1:0] entry_val;
  logic [VAL_W-1:0] rd_val;
  logic [IDX_W-1:0] rd_idx_q;

  torque_limit_table #(
    .DEPTH(ENTRIES),
    .WIDTH(VAL_W)
  ) u_table (
    .i_mclk(i_mclk),
    .i_rst(i_rst),
    .i_we(wr_ok),
    .i_waddr(req.addr[IDX_W-1:0]),
    .i_wdata(req.wdata[VAL_W-1:0]),
    .i_raddr(idx_q),
    .o_rdata(entry_val)
  );

  // shadow copy for software reads, kept beside the live table
  logic [VAL_W-1:0] shadow_q [ENTRIES];
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      for (int i = 0; i < ENTRIES; i++) begin
        shadow_q[i] <= VAL_W'(torque_limit_pkg::LIMIT_RESET);
      end
    end else if (wr_ok) begin
      shadow_q[req.addr[IDX_W-1:0]] <= req.wdata[VAL_W-1:0];
    end
  end
  assign rd_val = shadow_q[req.addr[IDX_W-1:0]];

  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      rd_idx_q <= '0;
    end else begin
      rd_idx_q <= idx_q;
    end
  end

  // ------------------------------------------------------------
  // clamp chain: instantaneous max, competing limit, homing bypass
  // ------------------------------------------------------------
  logic [VAL_W-1:0] capped;
  logic [VAL_W-1:0] merged;
  logic [VAL_W-1:0] limit_d;
  logic [VAL_W-1:0] limit_q;
  logic active_d;
  logic active_q;

  always_comb begin
    capped = (entry_val > inst_max_q) ? inst_max_q : entry_val;
    merged = capped;
    if (i_ext_limit_valid && i_ext_limit < capped) begin
      merged = i_ext_limit;
    end
    limit_d = merged;
    active_d = 1'b1;
    if (i_homing) begin
      // selected entry ignored; only the other source or motor max
      active_d = 1'b0;
      limit_d = inst_max_q;
      if (i_ext_limit_valid && i_ext_limit < inst_max_q) begin
        limit_d = i_ext_limit;
      end
    end
  end

  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      limit_q <= VAL_W'(torque_limit_pkg::LIMIT_RESET);
      active_q <= 1'b0;
    end else begin
      limit_q <= limit_d;
      active_q <= active_d;
    end
  end

  assign o_torque_limit_value = limit_q;
  assign o_limit_active = active_q;

  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      o_entry_index <= '0;
    end else begin
      o_entry_index <= 3'(rd_idx_q);
    end
  end

  // ------------------------------------------------------------
  // read port, data one cycle after strobe
  // ------------------------------------------------------------
  logic [15:0] status_word;

  // moving, homing, table limit in force, live index
  assign status_word = {4'h0, i_moving, i_homing, active_q, 6'(idx_q), 3'h0};

  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      o_rdata <= '0;
    end else if (req.rd) begin
      if (req.addr < 8'(ENTRIES)) begin
        o_rdata <= 16'(rd_val);
      end else if (req.addr == torque_limit_pkg::ADDR_INST_MAX) begin
        o_rdata <= 16'(inst_max_q);
      end else if (req.addr == torque_limit_pkg::ADDR_SEL_BIT) begin
        o_rdata <= 16'(sel_bit_q);
      end else if (req.addr == torque_limit_pkg::ADDR_STATUS) begin
        o_rdata <= status_word;
      end else begin
        o_rdata <= 16'h0000;
      end
    end else begin
      o_rdata <= 16'h0000;
    end
  end
endmodule // max_torque_limit_select
`default_nettype wire

// file: verification/max_torque_limit_select_sva.sv
// checker for the torque limit selector ports
// assumes it is bound to the top module, one clock domain
`timescale 1ns/1ps
`default_nettype none
module max_torque_limit_select_sva #(
  parameter int unsigned ENTRIES = 8,
  parameter int unsigned VAL_W = 10,
  parameter int unsigned PORT_W = 16
) (
  input wire logic i_mclk,
  input wire logic i_rst,
  input wire logic [PORT_W-1:0] i_gp_in,
  input wire logic i_homing,
  input wire logic i_ext_limit_valid,
  input wire logic [VAL_W-1:0] i_ext_limit,
  input wire logic [7:0] i_addr,
  input wire logic [15:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [15:0] o_rdata,
  input wire logic [VAL_W-1:0] o_torque_limit_value,
  input wire logic o_limit_active,
  input wire logic [2:0] o_entry_index
);
  logic [3:0] sel_q;
  logic [2:0] gp_sel;
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_rst);
  // ------------------------------------------------------------
  // select bit position shadow
  // ------------------------------------------------------------
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) sel_q <= torque_limit_pkg::SEL_BIT_RESET;
    else if (i_wr && i_addr == torque_limit_pkg::ADDR_SEL_BIT && i_wdata <= 16'h000d)
      sel_q <= i_wdata[3:0];
  end
  assign gp_sel = i_gp_in[sel_q +: 3];
  // ------------------------------------------------------------
  // properties
  // ------------------------------------------------------------
  a_ext_lower: assert property ($past(i_ext_limit_valid && !i_rst) |->
    o_torque_limit_value <= $past(i_ext_limit)) else $error("limit above other source");
  a_ext_zero: assert property ($past(i_ext_limit_valid && i_ext_limit == '0 && !i_rst) |->
    o_torque_limit_value == '0) else $error("zero other limit not applied");
  a_homing_off: assert property ($past(i_homing) |-> !o_limit_active)
    else $error("table limit active while homing");
  a_active_on: assert property ($past(!i_homing && !i_rst) |-> o_limit_active)
    else $error("table limit inactive outside homing");
  a_index_track: assert property ($stable(gp_sel) [*8] |-> o_entry_index == gp_sel)
    else $error("entry index does not follow stable bits");
  a_below_max: assert property (o_torque_limit_value <= torque_limit_pkg::LIMIT_MAX)
    else $error("limit above top of range");
  a_reset_value: assert property ($fell(i_rst) |->
    o_torque_limit_value == torque_limit_pkg::LIMIT_RESET && o_entry_index == 3'h0)
    else $error("wrong value after reset");
  a_read_idle: assert property (!$past(i_rd) |-> o_rdata == 16'h0000)
    else $error("read data outside read slot");
endmodule // max_torque_limit_select_sva
`default_nettype wire

// file: verification/gp_ctrl_model.sv
// external controller driving the general purpose input port
// assumes the bench picks index, bit position and glitches
`timescale 1ns/1ps
`default_nettype none
module gp_ctrl_model (
  input wire logic i_mclk,
  input wire logic i_rst,
  input wire logic [2:0] i_idx,
  input wire logic [3:0] i_pos,
  input wire logic i_glitch,
  output logic [15:0] o_gp
);
  logic [15:0] noise_q;
  // unrelated bits change every cycle
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) noise_q <= 16'ha5c3;
    else noise_q <= {noise_q[14:0], ~noise_q[15]};
  end
  // one axis, index on three adjacent bits, lowest bit weight one
  assign o_gp = (noise_q & ~(16'h0007 << i_pos)) | (16'(i_glitch ? ~i_idx : i_idx) << i_pos);
endmodule // gp_ctrl_model
`default_nettype wire

// file: verification/tb_max_torque_limit_select.sv
// directed bench for the torque limit selector
// assumes the controller model and the bound checker
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, s) begin n_compared++; if ((s) !== (e)) begin mismatches++; \
  $display("[ERR] %s exp %h got %h", n, e, s); end end
module tb_max_torque_limit_select;
  logic i_mclk = 1'b0, i_rst = 1'b1, i_homing = 1'b0, i_moving = 1'b0, ev = 1'b0;
  logic i_wr = 1'b0, i_rd = 1'b0, gl = 1'b0, o_limit_active;
  logic [9:0] ext = 10'h000, o_torque_limit_value;
  logic [7:0] i_addr = 8'h00;
  logic [15:0] i_wdata = 16'h0000, o_rdata, gp;
  logic [2:0] idx = 3'h0, o_entry_index;
  logic [3:0] pos = 4'h0;
  int mismatches = 0, n_compared = 0;
  always #2.5 i_mclk = ~i_mclk;
  gp_ctrl_model u_ctrl (.i_mclk(i_mclk), .i_rst(i_rst), .i_idx(idx), .i_pos(pos),
    .i_glitch(gl), .o_gp(gp));
  max_torque_limit_select u_dut (.i_mclk(i_mclk), .i_rst(i_rst), .i_gp_in(gp),
    .i_homing(i_homing), .i_moving(i_moving), .i_ext_limit_valid(ev), .i_ext_limit(ext),
    .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
    .o_torque_limit_value(o_torque_limit_value), .o_limit_active(o_limit_active),
    .o_entry_index(o_entry_index));
  // ------------------------------------------------------------
  // bus and check tasks
  // ------------------------------------------------------------
  function automatic logic [9:0] ev_of(input int i);
    return 10'(100 + 50 * i);
  endfunction
  task wr_reg(input logic [7:0] a, input logic [15:0] d);
    @(posedge i_mclk);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_mclk);
    i_wr <= 1'b0;
  endtask
  task rd_chk(input logic [7:0] a, input logic [15:0] e);
    @(posedge i_mclk);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_mclk);
    i_rd <= 1'b0;
    #1 `CHK("rdata", e, o_rdata)
  endtask
  task sel_idx(input logic [2:0] v);
    @(posedge i_mclk);
    idx <= v;
    wait_n(8);
  endtask
  task wait_n(input int n);
    repeat (n) @(posedge i_mclk);
    #1;
  endtask
  task chk_lim(input logic [9:0] e);
    `CHK("limit", e, o_torque_limit_value)
  endtask
  task tally_and_finish;
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    #200000;
    mismatches++;
    tally_and_finish();
  end
  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  initial begin
    repeat (2) @(posedge i_mclk);
    i_rst <= 1'b0;
    wait_n(1);
    chk_lim(torque_limit_pkg::LIMIT_RESET);
    for (int i = 0; i < 8; i++) rd_chk(8'(i), {6'h00, torque_limit_pkg::LIMIT_RESET});
    wr_reg(torque_limit_pkg::ADDR_INST_MAX, 16'h03e7);
    for (int i = 0; i < 8; i++) wr_reg(8'(i), {6'h00, ev_of(i)});
    for (int i = 0; i < 8; i++) begin
      sel_idx(3'(i));
      `CHK("index", 3'(i), o_entry_index)
      chk_lim(ev_of(i));
    end
    wr_reg(8'h00, 16'h0000);
    wr_reg(8'h00, 16'h03e8);
    wr_reg(8'h00, 16'h0464);
    rd_chk(8'h00, 16'h0064);
    wr_reg(8'h00, 16'h03e7);
    rd_chk(8'h00, 16'h03e7);
    wr_reg(8'h00, 16'h0001);
    rd_chk(8'h00, 16'h0001);
    wr_reg(8'h01, 16'h03e7);
    sel_idx(3'h1);
    chk_lim(10'h3e7);
    wr_reg(torque_limit_pkg::ADDR_INST_MAX, 16'h012c);
    wait_n(3);
    chk_lim(10'h12c);
    wr_reg(8'h01, 16'h00c8);
    wait_n(3);
    chk_lim(10'h0c8);
    @(posedge i_mclk);
    i_moving <= 1'b1;
    sel_idx(3'h3);
    chk_lim(ev_of(3));
    rd_chk(torque_limit_pkg::ADDR_STATUS, 16'h0a18);
    @(posedge i_mclk);
    i_moving <= 1'b0;
    ev <= 1'b1;
    ext <= 10'h000;
    wait_n(3);
    chk_lim(10'h000);
    @(posedge i_mclk);
    ext <= 10'h078;
    wait_n(3);
    chk_lim(10'h078);
    @(posedge i_mclk);
    ext <= 10'h3e0;
    wait_n(3);
    chk_lim(ev_of(3));
    @(posedge i_mclk);
    ev <= 1'b0;
    i_homing <= 1'b1;
    wait_n(3);
    chk_lim(10'h12c);
    `CHK("active", 1'b0, o_limit_active)
    rd_chk(torque_limit_pkg::ADDR_STATUS, 16'h0418);
    @(posedge i_mclk);
    ev <= 1'b1;
    ext <= 10'h064;
    wait_n(3);
    chk_lim(10'h064);
    @(posedge i_mclk);
    ev <= 1'b0;
    i_homing <= 1'b0;
    gl <= 1'b1;
    @(posedge i_mclk);
    gl <= 1'b0;
    wait_n(8);
    `CHK("index", 3'h3, o_entry_index)
    `CHK("active", 1'b1, o_limit_active)
    wr_reg(torque_limit_pkg::ADDR_SEL_BIT, 16'h000e);
    wr_reg(torque_limit_pkg::ADDR_SEL_BIT, 16'h0013);
    rd_chk(torque_limit_pkg::ADDR_SEL_BIT, 16'h0000);
    wr_reg(torque_limit_pkg::ADDR_SEL_BIT, 16'h0005);
    @(posedge i_mclk);
    pos <= 4'h5;
    idx <= 3'h6;
    wait_n(8);
    `CHK("index", 3'h6, o_entry_index)
    rd_chk(8'h20, 16'h0000);
    @(posedge i_mclk);
    i_rst <= 1'b1;
    @(posedge i_mclk);
    i_rst <= 1'b0;
    wait_n(1);
    chk_lim(torque_limit_pkg::LIMIT_RESET);
    rd_chk(8'h01, {6'h00, torque_limit_pkg::LIMIT_RESET});
    tally_and_finish();
  end
endmodule // tb_max_torque_limit_select
bind max_torque_limit_select max_torque_limit_select_sva #(.ENTRIES(ENTRIES), .VAL_W(VAL_W),
  .PORT_W(PORT_W)) u_sva (.i_mclk(i_mclk), .i_rst(i_rst), .i_gp_in(i_gp_in),
  .i_homing(i_homing), .i_ext_limit_valid(i_ext_limit_valid), .i_ext_limit(i_ext_limit),
  .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
  .o_torque_limit_value(o_torque_limit_value), .o_limit_active(o_limit_active),
  .o_entry_index(o_entry_index));
`default_nettype wire
